// File: rtl/fml_cfg.sv
`timescale 1ns/1ps

module fml_cfg #(
   parameter int CNT_W = 10 // width of the lock count field
) (
   input  wire logic                       clk_i,
   input  wire logic                       resetn_i,
   // register port from the serial interface decoder
   input  wire logic                       reg_wr_i,        // one-cycle write strobe
   input  wire logic [4:0]                 reg_waddr_i,
   input  wire logic [fml_pkg::FML_DW-1:0] reg_wdata_i,
   input  wire logic [4:0]                 reg_raddr_i,
   output logic      [fml_pkg::FML_DW-1:0] reg_rdata_o,     // one cycle behind raddr
   // modulator side
   input  wire logic                       refdiv_clk_i,    // reference divider output
   input  wire logic                       vcodiv_clk_i,    // vco divider output
   input  wire logic [3:0]                 mod_out_i,       // raw modulator output
   input  wire logic                       sdi_i,           // serial data input pin
   output logic                            mod_clk_o,
   output logic [3:0]                      mod_out_o,       // modulator output used
   output logic                            core_rst_o,
   output logic                            buf_rst_o,
   output logic                            frac_mode_o,
   output logic [fml_pkg::FML_DW-1:0]      frac_o,
   output logic [fml_pkg::FML_DW-1:0]      seed_o,          // seed or fsk f1
   output logic                            seed_load_o,     // one-cycle pulse
   output logic                            fsk_en_o,
   output logic                            fsk_data_o,
   output logic [1:0]                      mod_type_o,
   output logic                            type_a_o,
   output logic                            modulator_spare_bit_o,
   // lock detect and slip prevention side
   input  wire logic                       div_evt_i,       // divided vco edge event
   input  wire logic                       in_window_i,     // that edge was in window
   input  wire logic                       phase_lead_i,    // vco ahead of reference
   input  wire logic                       slip_i,          // slip pending at pfd
   input  wire logic                       lock_output_drive_on_i,
   output logic                            lock_o,
   output logic                            lock_readback_pin_o,
   output logic                            win_asym_o,
   output logic                            win_lead_o,
   output logic                            win_lag_o,
   output logic                            os_ring_o,
   output logic [2:0]                      os_dur_o,
   output logic [1:0]                      ro_trim_o,
   output logic                            ro_on_o,
   output logic                            csp_en_o,
   output logic                            csp_act_o,       // correction applied
   output logic                            csp_sign_o,      // 1 = pull down
   output logic [3:0]                      csp_mag_o
);
   import fml_pkg::*;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [FML_DW-1:0] mod_q;   // modulator_config
   logic [FML_DW-1:0] lck_q;   // lock_detect_slip_config
   logic [FML_DW-1:0] frac_q;  // fractional word
   logic [FML_DW-1:0] seed_q;  // seed / fsk f1
   logic              frac_wr; // frac register written this cycle

   assign frac_wr = reg_wr_i && (reg_waddr_i == FML_ADDR_FRAC);

   // writes store every bit as given except lock bits 23..21, which are masked; bit 14 is trusted to be zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mod_q  <= MOD_RESET;
         lck_q  <= LCK_RESET;
         frac_q <= FRAC_RESET;
         seed_q <= SEED_RESET;
      end else if (reg_wr_i) begin
         case (reg_waddr_i)
            FML_ADDR_MOD:  mod_q  <= reg_wdata_i & MOD_WMASK;
            FML_ADDR_LOCK: lck_q  <= reg_wdata_i & LCK_WMASK;
            FML_ADDR_FRAC: frac_q <= reg_wdata_i;
            FML_ADDR_SEED: seed_q <= reg_wdata_i;
            default: ;                                        // other registers live elsewhere
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // registered so the serial shifter sees a stable word
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= '0;
      end else begin
         case (reg_raddr_i)
            FML_ADDR_MOD:  reg_rdata_o <= mod_q;
            FML_ADDR_LOCK: reg_rdata_o <= lck_q;
            FML_ADDR_FRAC: reg_rdata_o <= frac_q;
            FML_ADDR_SEED: reg_rdata_o <= seed_q;
            default:       reg_rdata_o <= '0; // not held by this block
         endcase
      end
   end

   // ----------------------------------------------------------------
   // modulator control
   // ----------------------------------------------------------------
   logic core_run; // core released from reset
   logic buf_run;  // buffers released from reset
   logic out_ign;  // modulator output ignored
   assign core_run = mod_q[MOD_CORE_RUN];
   assign buf_run  = mod_q[MOD_BUF_RUN];
   assign out_ign  = mod_q[MOD_OUT_IGN];

   // static decodes, registered so every output leaves a flop
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mod_type_o            <= FML_TYPE_B;
         type_a_o              <= 1'b0;
         core_rst_o            <= 1'b1;
         buf_rst_o             <= 1'b1;
         frac_mode_o           <= 1'b0;
         frac_o                <= FRAC_RESET;
         seed_o                <= SEED_RESET;
         fsk_en_o              <= 1'b0;
         modulator_spare_bit_o <= 1'b0;
      end else begin
         mod_type_o            <= mod_q[MOD_TYPE_LO +: 2];
         type_a_o              <= mod_q[MOD_TYPE_LO +: 2] == FML_TYPE_A;
         core_rst_o            <= !core_run;
         buf_rst_o             <= !buf_run;
         // fractional operation only with the 011 setting of bits 12..10
         frac_mode_o           <= core_run && buf_run && !out_ign;
         frac_o                <= frac_q;
         seed_o                <= seed_q;
         fsk_en_o              <= mod_q[MOD_FSK_EN];
         modulator_spare_bit_o <= mod_q[MOD_SPARE];
      end
   end

   // modulator output is zeroed when ignored; the core keeps running
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mod_out_o <= '0;
      end else if (out_ign || !core_run) begin
         mod_out_o <= '0;
      end else begin
         mod_out_o <= mod_out_i;
      end
   end

   // clock pick and polarity; a flop adds one cycle of skew, which is
   // acceptable as the divider outputs are themselves synchronous here
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mod_clk_o <= 1'b0;
      end else begin
         mod_clk_o <= (mod_q[MOD_CLK_REF] ? refdiv_clk_i : vcodiv_clk_i)
                      ^ mod_q[MOD_CLK_INV];
      end
   end

   // seed load pulse on each frac write while autoseed is on
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seed_load_o <= 1'b0;
      end else begin
         seed_load_o <= frac_wr && mod_q[MOD_AUTOSEED];
      end
   end

   // serial data pin doubles as fsk input only in fsk operation
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fsk_data_o <= 1'b0;
      end else begin
         fsk_data_o <= mod_q[MOD_FSK_EN] ? sdi_i : 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // lock window and slip prevention configuration outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         win_asym_o <= 1'b0;
         win_lead_o <= 1'b1;
         win_lag_o  <= 1'b1;
         os_ring_o  <= 1'b0;
         os_dur_o   <= '0;
         ro_trim_o  <= '0;
         ro_on_o    <= 1'b0;
         csp_en_o   <= 1'b1;
         csp_mag_o  <= MOD_RESET[MOD_CSP_LO +: 4];
      end else begin
         win_asym_o <= lck_q[LCK_ASYM];
         // symmetric window spans both sides; asymmetric keeps one
         win_lead_o <= !lck_q[LCK_ASYM] || lck_q[LCK_LEAD];
         win_lag_o  <= !lck_q[LCK_ASYM] || !lck_q[LCK_LEAD];
         os_ring_o  <= lck_q[LCK_OS_RING];
         os_dur_o   <= lck_q[LCK_OS_DUR +: 3];
         ro_trim_o  <= lck_q[LCK_RO_TRIM +: 2];
         // ring runs when forced or when it times the window
         ro_on_o    <= lck_q[LCK_RO_FORCE] || lck_q[LCK_OS_RING];
         csp_en_o   <= lck_q[LCK_CSP_EN];
         csp_mag_o  <= mod_q[MOD_CSP_LO +: 4];
      end
   end

   // ----------------------------------------------------------------
   // slip prevention correction
   // ----------------------------------------------------------------
   // sign follows the phase error direction, never software
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         csp_act_o  <= 1'b0;
         csp_sign_o <= 1'b0;
      end else begin
         csp_act_o  <= lck_q[LCK_CSP_EN] && slip_i;
         csp_sign_o <= phase_lead_i;
      end
   end

   // ----------------------------------------------------------------
   // lock detector
   // ----------------------------------------------------------------
   fml_lock_e         lk_q;    // detector state
   logic [CNT_W-1:0]  cnt_q;   // consecutive in-window events
   logic [CNT_W-1:0]  cnt_max; // programmed target
   logic              lk_en;   // detection enabled

   assign cnt_max = lck_q[LCK_CNT_LO +: CNT_W];
   assign lk_en   = lck_q[LCK_EN];

   // one miss restarts the run; a zero target locks on first hit
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lk_q  <= FML_LK_IDLE;
         cnt_q <= '0;
      end else if (!lk_en) begin
         lk_q  <= FML_LK_IDLE;
         cnt_q <= '0;
      end else if (div_evt_i) begin
         case (lk_q)
            FML_LK_IDLE, FML_LK_COUNT: begin
               if (!in_window_i) begin
                  lk_q  <= FML_LK_COUNT;
                  cnt_q <= '0;
               end else if (cnt_q + 1'b1 >= cnt_max) begin
                  lk_q  <= FML_LK_LOCK;
                  cnt_q <= cnt_max;
               end else begin
                  lk_q  <= FML_LK_COUNT;
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            FML_LK_LOCK: begin
               if (!in_window_i) begin
                  lk_q  <= FML_LK_COUNT;            // lost lock, count again
                  cnt_q <= '0;
               end
            end
            default: begin
               lk_q  <= FML_LK_IDLE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // lock flag and shared pin; pin stays low unless its drive is on
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock_o              <= 1'b0;
         lock_readback_pin_o <= 1'b0;
      end else begin
         lock_o              <= lk_en && (lk_q == FML_LK_LOCK);
         lock_readback_pin_o <= lock_output_drive_on_i && lk_en
                                && (lk_q == FML_LK_LOCK);
      end
   end

endmodule // fml_cfg

// File: rtl/fml_pkg.sv
package fml_pkg;

   // ----------------------------------------------------------------
   // register addresses on the serial register port
   // ----------------------------------------------------------------
   localparam logic [4:0] FML_ADDR_FRAC = 5'h04; // fractional frequency word
   localparam logic [4:0] FML_ADDR_SEED = 5'h05; // modulator seed / fsk f1
   localparam logic [4:0] FML_ADDR_MOD  = 5'h06; // modulator_config
   localparam logic [4:0] FML_ADDR_LOCK = 5'h07; // lock_detect_slip_config

   localparam int FML_DW = 24; // register data width

   // ----------------------------------------------------------------
   // modulator_config field positions
   // ----------------------------------------------------------------
   localparam int MOD_RSVD_LO  = 0;  // [7:0] reserved, keeps written value
   localparam int MOD_TYPE_LO  = 8;  // [9:8] modulator type
   localparam int MOD_CORE_RUN = 10; // fractional core reset release
   localparam int MOD_BUF_RUN  = 11; // core buffer reset release
   localparam int MOD_OUT_IGN  = 12; // discard modulator output
   localparam int MOD_AUTOSEED = 13; // seed on every frac write
   localparam int MOD_RSVD14   = 14; // must stay zero
   localparam int MOD_FSK_EN   = 15; // fsk operation
   localparam int MOD_CLK_REF  = 17; // 1 = reference divider clock
   localparam int MOD_CLK_INV  = 18; // invert selected modulator clock
   localparam int MOD_SPARE    = 19; // modulator_spare_bit
   localparam int MOD_CSP_LO   = 20; // [23:20] slip correction magnitude

   localparam logic [23:0] MOD_RESET = 24'h842e87; // documented defaults
   localparam logic [23:0] MOD_WMASK = 24'hffffff; // all bits writable

   // ----------------------------------------------------------------
   // lock_detect_slip_config field positions
   // ----------------------------------------------------------------
   localparam int LCK_CNT_LO   = 0;  // [9:0] consecutive in-window count
   localparam int LCK_EN       = 10; // lock detect enable
   localparam int LCK_ASYM     = 11; // asymmetric window enable
   localparam int LCK_LEAD     = 12; // 1 = leading window, 0 = lagging
   localparam int LCK_OS_RING  = 13; // 1 = ring oscillator one-shot
   localparam int LCK_OS_DUR   = 14; // [16:14] ring one-shot duration
   localparam int LCK_RO_TRIM  = 17; // [18:17] ring oscillator trim
   localparam int LCK_RO_FORCE = 19; // force ring oscillator on
   localparam int LCK_CSP_EN   = 20; // cycle slip prevention enable

   localparam logic [23:0] LCK_RESET = 24'h1014fa; // 250, enables, lead
   localparam logic [23:0] LCK_WMASK = 24'h1fffff; // [23:21] read zero

   localparam logic [23:0] FRAC_RESET = 24'h000000;
   localparam logic [23:0] SEED_RESET = 24'h000000;

   // one-shot nominal width of the analog window, for reference only
   localparam int FML_ANALOG_OS_NS = 20;

   // modulator type codes
   localparam logic [1:0] FML_TYPE_B = 2'h2;
   localparam logic [1:0] FML_TYPE_A = 2'h3;

   // lock detector states, one-hot
   typedef enum logic [2:0] {
      FML_LK_IDLE  = 3'b001,
      FML_LK_COUNT = 3'b010,
      FML_LK_LOCK  = 3'b100
   } fml_lock_e;

endpackage : fml_pkg

// File: verification/fml_cfg_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker for the modulator and lock detect register bank
// ----------------------------------------------------------------
module fml_cfg_chk (
   input wire logic                       clk_i,
   input wire logic                       resetn_i,
   input wire logic                       reg_wr_i,
   input wire logic [4:0]                 reg_waddr_i,
   input wire logic [fml_pkg::FML_DW-1:0] reg_wdata_i,
   input wire logic                       sdi_i,
   input wire logic                       div_evt_i,
   input wire logic                       in_window_i,
   input wire logic                       slip_i,
   input wire logic [1:0]                 mod_type_o,
   input wire logic                       type_a_o,
   input wire logic                       core_rst_o,
   input wire logic                       buf_rst_o,
   input wire logic                       frac_mode_o,
   input wire logic                       seed_load_o,
   input wire logic                       fsk_en_o,
   input wire logic                       fsk_data_o,
   input wire logic                       lock_o,
   input wire logic                       win_asym_o,
   input wire logic                       win_lead_o,
   input wire logic                       win_lag_o,
   input wire logic                       csp_en_o,
   input wire logic                       csp_act_o
);
   import fml_pkg::*;

   // all checks live in the one clock domain
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // write strobe aimed at modulator_config
   logic mod_wr;
   assign mod_wr = reg_wr_i && (reg_waddr_i == FML_ADDR_MOD);

   // decoded outputs follow a write two edges later, even back to back
   type_code_a: assert property (mod_wr |-> ##2 (mod_type_o == $past(reg_wdata_i[9:8], 2)
      && type_a_o == ($past(reg_wdata_i[9:8], 2) == FML_TYPE_A)))
      else $error("type A flag disagrees with type field");
   core_hold_a: assert property (mod_wr |-> ##2 core_rst_o == !$past(reg_wdata_i[10], 2))
      else $error("core reset does not follow its release bit");
   buf_hold_a: assert property (mod_wr |-> ##2 buf_rst_o == !$past(reg_wdata_i[11], 2))
      else $error("buffer reset does not follow its release bit");
   frac_mode_a: assert property (mod_wr |-> ##2
      frac_mode_o == ($past(reg_wdata_i[12:10], 2) == 3'b011))
      else $error("fractional mode flag wrong after write");
   seed_pulse_a: assert property (seed_load_o |-> $past(reg_wr_i && reg_waddr_i == FML_ADDR_FRAC))
      else $error("seed load without a fraction write");
   fsk_input_a: assert property (fsk_data_o == (fsk_en_o && $past(sdi_i)))
      else $error("fsk data not taken from serial input");
   sym_window_a: assert property (!win_asym_o |-> win_lead_o && win_lag_o)
      else $error("symmetric window lost one side");
   side_window_a: assert property (win_asym_o |-> win_lead_o != win_lag_o)
      else $error("asymmetric window not one-sided");
   lock_drop_a: assert property (div_evt_i && !in_window_i |-> ##2 !lock_o)
      else $error("lock held after out-of-window event");
   // slip input must be low through reset, else the first sample trips this
   slip_act_a: assert property (csp_act_o == (csp_en_o && $past(slip_i)))
      else $error("slip correction active while disabled");
endmodule // fml_cfg_chk

// File: verification/tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// self-checking bench, inputs change on the falling edge
// ----------------------------------------------------------------
module tb;
   import fml_pkg::*;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic [4:0]  reg_waddr_i = 5'h00;
   logic [23:0] reg_wdata_i = 24'h000000;
   logic [4:0]  reg_raddr_i = 5'h00;
   logic        refdiv_clk_i = 1'b1;    // held opposite to vco divider
   logic        vcodiv_clk_i = 1'b0;    // so the selected source shows
   logic [3:0]  mod_out_i = 4'ha;
   logic        sdi_i = 1'b1;
   logic        div_evt_i = 1'b0;
   logic        in_window_i = 1'b0;
   logic        phase_lead_i = 1'b0;    // low in reset; the checker watches slip_i, not this
   logic        slip_i = 1'b0;
   logic        lock_output_drive_on_i = 1'b0;
   logic [23:0] reg_rdata_o, frac_o, seed_o;
   logic [3:0]  mod_out_o, csp_mag_o;
   logic [2:0]  os_dur_o;
   logic [1:0]  mod_type_o, ro_trim_o;
   logic        mod_clk_o, core_rst_o, buf_rst_o, frac_mode_o, seed_load_o, fsk_en_o;
   logic        fsk_data_o, type_a_o, modulator_spare_bit_o, lock_o, lock_readback_pin_o;
   logic        win_asym_o, win_lead_o, win_lag_o, os_ring_o, ro_on_o, csp_en_o;
   logic        csp_act_o, csp_sign_o;
   int          fails = 0;
   int          compares = 0;

   fml_cfg dut (
      .clk_i, .resetn_i, .reg_wr_i, .reg_waddr_i, .reg_wdata_i, .reg_raddr_i, .reg_rdata_o,
      .refdiv_clk_i, .vcodiv_clk_i, .mod_out_i, .sdi_i, .mod_clk_o, .mod_out_o, .core_rst_o,
      .buf_rst_o, .frac_mode_o, .frac_o, .seed_o, .seed_load_o, .fsk_en_o, .fsk_data_o,
      .mod_type_o, .type_a_o, .modulator_spare_bit_o, .div_evt_i, .in_window_i, .phase_lead_i,
      .slip_i, .lock_output_drive_on_i, .lock_o, .lock_readback_pin_o, .win_asym_o,
      .win_lead_o, .win_lag_o, .os_ring_o, .os_dur_o, .ro_trim_o, .ro_on_o, .csp_en_o,
      .csp_act_o, .csp_sign_o, .csp_mag_o
   );

   // 100 MHz clock
   initial forever #5 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one-cycle strobe; caller lets an edge pass before the next one
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      reg_wr_i = 1'b1;
      reg_waddr_i = a;
      reg_wdata_i = d;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask

   // read port is registered, so data is valid one edge later
   task automatic rd(input logic [4:0] a, output logic [23:0] v);
      reg_raddr_i = a;
      @(negedge clk_i);
      v = reg_rdata_o;
   endtask

   // n divided-vco events, then a quiet gap long enough for the flag
   task automatic evts(input int n, input logic inw);
      repeat (n) begin
         div_evt_i = 1'b1;
         in_window_i = inw;
         @(negedge clk_i);
      end
      div_evt_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [23:0] v;
      rd(FML_ADDR_MOD, v);
      chk("mod_reset", v, 24'h842e87);
      rd(FML_ADDR_LOCK, v);
      chk("lock_reset", v, 24'h1014fa);
      rd(5'h1f, v);
      chk("unmapped", v, 24'h000000);
      chk("type", mod_type_o, 2'h2);
      chk("csp_mag", csp_mag_o, 4'h8);
      chk("csp_en", csp_en_o, 1'b1);
      chk("win_lead", win_lead_o, 1'b1);
      chk("os_ring", os_ring_o, 1'b0);
      chk("ro_on", ro_on_o, 1'b0);
      chk("os_dur", os_dur_o, 3'h0);
      chk("ro_trim", ro_trim_o, 2'h0);
      $display("test reset done");
   endtask

   // one word per type code, mixing the reset and bypass bits
   task automatic t_mod;
      logic [23:0] v;
      logic [23:0] w [4] = '{24'h0a9987, 24'h703687, 24'hf48f87, 24'h2e3487};
      foreach (w[i]) begin
         wr(FML_ADDR_MOD, w[i]);
         @(negedge clk_i);
         chk("type", mod_type_o, w[i][9:8]);
         chk("type_a", type_a_o, w[i][9:8] == 2'h3);
         chk("core_rst", core_rst_o, !w[i][10]);
         chk("buf_rst", buf_rst_o, !w[i][11]);
         chk("mod_out", mod_out_o, (w[i][12] || !w[i][10]) ? 4'h0 : 4'ha);
         chk("frac_mode", frac_mode_o, w[i][12:10] == 3'b011);
         chk("fsk", fsk_data_o, w[i][15]);
         chk("fsk_en", fsk_en_o, w[i][15]);
         chk("spare", modulator_spare_bit_o, w[i][19]);
         chk("mod_clk", mod_clk_o, w[i][17] ^ w[i][18]);
         chk("csp_mag", csp_mag_o, w[i][23:20]);
         rd(FML_ADDR_MOD, v);
         chk("mod_rd", v, w[i]);
      end
      wr(FML_ADDR_MOD, 24'h842e87);
      $display("test modulator done");
   endtask

   task automatic t_seed;
      logic [23:0] v;
      @(negedge clk_i);
      wr(FML_ADDR_SEED, 24'h5a5a5a);
      @(negedge clk_i);
      wr(FML_ADDR_FRAC, 24'hffffff);
      chk("seed_load", seed_load_o, 1'b1);
      @(negedge clk_i);
      chk("seed_pulse", seed_load_o, 1'b0);
      chk("seed", seed_o, 24'h5a5a5a);
      chk("frac", frac_o, 24'hffffff);
      wr(FML_ADDR_MOD, 24'h840e87);
      @(negedge clk_i);
      wr(FML_ADDR_FRAC, 24'h000001);
      chk("no_seed", seed_load_o, 1'b0);
      @(negedge clk_i);
      wr(FML_ADDR_MOD, 24'h842e87);
      // leakage setting lives in the charge pump register, outside this bank
      @(negedge clk_i);
      wr(5'h09, 24'h000080);
      rd(FML_ADDR_MOD, v);
      chk("leak_wr_ignored", v, 24'h842e87);
      $display("test seed done");
   endtask

   task automatic t_lock;
      @(negedge clk_i);
      wr(FML_ADDR_LOCK, 24'h100405);
      @(negedge clk_i);
      evts(4, 1'b1);
      chk("lock_early", lock_o, 1'b0);
      evts(1, 1'b1);
      chk("lock", lock_o, 1'b1);
      chk("pin_off", lock_readback_pin_o, 1'b0);
      lock_output_drive_on_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("pin_on", lock_readback_pin_o, 1'b1);
      evts(1, 1'b0);
      chk("lock_lost", lock_o, 1'b0);
      // detector off, lagging one-sided window, ring one-shot, slip off
      wr(FML_ADDR_LOCK, 24'h076805);
      evts(6, 1'b1);
      chk("lock_off", lock_o, 1'b0);
      chk("win_asym", win_asym_o, 1'b1);
      chk("win_lag", win_lag_o, 1'b1);
      chk("os_ring", os_ring_o, 1'b1);
      chk("os_dur", os_dur_o, 3'h5);
      chk("ro_trim", ro_trim_o, 2'h3);
      chk("win_lead", win_lead_o, 1'b0);
      chk("ro_on", ro_on_o, 1'b1);
      chk("csp_en_off", csp_en_o, 1'b0);
      slip_i = 1'b1;
      phase_lead_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("csp_off", csp_act_o, 1'b0);
      wr(FML_ADDR_LOCK, 24'h1014fa);
      repeat (2) @(negedge clk_i);
      chk("csp_on", csp_act_o, 1'b1);
      chk("csp_sign", csp_sign_o, 1'b1);
      $display("test lock done");
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // tests need well under 1000 cycles; twenty times that is a hang
   initial begin
      #(20000 * 10);
      fails++;
      end_of_test;
   end

   initial begin
      repeat (20) @(negedge clk_i);
      resetn_i = 1'b1;
      @(negedge clk_i);
      t_reset;
      t_mod;
      t_seed;
      t_lock;
      end_of_test;
   end
endmodule // tb

bind fml_cfg fml_cfg_chk u_chk (
   .clk_i, .resetn_i, .reg_wr_i, .reg_waddr_i, .reg_wdata_i, .sdi_i, .div_evt_i,
   .in_window_i, .slip_i, .mod_type_o, .type_a_o, .core_rst_o, .buf_rst_o, .frac_mode_o,
   .seed_load_o, .fsk_en_o, .fsk_data_o, .lock_o, .win_asym_o, .win_lead_o, .win_lag_o,
   .csp_en_o, .csp_act_o
);
